// [qid_datapath.sv]
// Purpose: Premodulation and three cascadable half-band interpolators on an I/Q stream
// Assumes: One clock; samples move by valid/ready; the sink may stall at will
// Notes:   Short four-tap kernel; sweeping rotations place each stage's pass band
`timescale 1ns/1ns
`include "qid_defs.svh"
module qid_datapath #(
    parameter int FIFO_DEPTH = `QID_FIFO_DEPTH
) (
    input  wire logic                         core_clk,
    input  wire logic                         rst_n,
    input  wire qid_pkg::qid_sample_t         in_i,
    input  wire qid_pkg::qid_sample_t         in_q,
    input  wire logic                         in_valid,
    output logic                              in_ready,
    input  wire logic                         premod_enable,
    input  wire logic                         halfband_stage_first_bypass,
    input  wire logic                         halfband_stage_second_bypass,
    input  wire logic                         halfband_stage_third_bypass,
    input  wire logic [`QID_HB1_MODE_W-1:0]   halfband_stage_first_mode,
    input  wire logic [`QID_HBN_MODE_W-1:0]   halfband_stage_second_mode,
    input  wire logic [`QID_HBN_MODE_W-1:0]   halfband_stage_third_mode,
    output qid_pkg::qid_sample_t              out_i,
    output qid_pkg::qid_sample_t              out_q,
    output logic                              out_valid,
    input  wire logic                         out_ready
);
    import qid_pkg::*;

    localparam int NS = `QID_NUM_STAGES;
    localparam int W  = `QID_DATA_W;

    qid_state_s             st;
    qid_state_s             next_st;
    logic [2*W-1:0]         fifo_data;
    logic                   fifo_valid;
    logic                   fifo_take;
    logic [NS-1:0]          take;
    logic [NS-1:0]          accept;
    logic [NS-1:0]          byp;
    qid_mode_t              mode [NS];
    logic                   down_rdy;
    qid_sample_t            src_i;
    qid_sample_t            src_q;
    logic                   src_v;
    logic [2*W-1:0]         rot;
    logic [2*W-1:0]         ev;
    logic [2*W-1:0]         od;
    logic [1:0]             step_in;
    logic [2:0]             step_out;
    logic [`QID_TAPS-1:0][W-1:0] nt_i;
    logic [`QID_TAPS-1:0][W-1:0] nt_q;

    // Input buffer; stage one's take is the drain, so a stall reaches in_ready
    qid_fifo #(
        .WIDTH (2*W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .wr_data  ({in_i, in_q}),
        .wr_valid (in_valid),
        .wr_ready (in_ready),
        .rd_data  (fifo_data),
        .rd_valid (fifo_valid),
        .rd_ready (fifo_take)
    );

    // Clip a wide sum to one sample
    function automatic qid_sample_t sat(input logic signed [35:0] x);
        if (x > `QID_SAT_MAX) begin
            return qid_sample_t'(`QID_SAT_MAX);
        end else if (x < `QID_SAT_MIN) begin
            return qid_sample_t'(`QID_SAT_MIN);
        end
        return qid_sample_t'(x);
    endfunction

    // Quarter-turn rotation, counter-clockwise by idx times 90 degrees
    function automatic logic [2*W-1:0] rot_q(input qid_sample_t i, input qid_sample_t q,
                                              input logic [1:0] idx);
        logic signed [35:0] ei;
        logic signed [35:0] eq;
        ei = 36'(i);
        eq = 36'(q);
        case (idx)
            2'h0: return {sat(ei), sat(eq)};
            2'h1: return {sat(-eq), sat(ei)};
            2'h2: return {sat(-ei), sat(-eq)};
            2'h3: return {sat(eq), sat(-ei)};
            default: return {i, q};
        endcase
    endfunction

    // Eighth-turn rotation; odd steps cost one scale by one over root two
    function automatic logic [2*W-1:0] rot_e(input qid_sample_t i, input qid_sample_t q,
                                              input logic [2:0] idx);
        logic [2*W-1:0]     r;
        logic signed [35:0] a;
        logic signed [35:0] b;
        r = rot_q(i, q, idx[2:1]);
        a = 36'(qid_sample_t'(r[2*W-1:W]));
        b = 36'(qid_sample_t'(r[W-1:0]));
        if (idx[0]) begin
            r = {sat(((a - b) * `QID_ROOT_HALF) >>> `QID_ROOT_SHIFT),
                 sat(((a + b) * `QID_ROOT_HALF) >>> `QID_ROOT_SHIFT)};
        end
        return r;
    endfunction

    // Odd phase of the half-band kernel, midway between taps 2 and 1
    function automatic qid_sample_t hb_odd(input logic [`QID_TAPS-1:0][W-1:0] t);
        logic signed [35:0] near;
        logic signed [35:0] far;
        near = 36'(qid_sample_t'(t[1])) + 36'(qid_sample_t'(t[2]));
        far  = 36'(qid_sample_t'(t[0])) + 36'(qid_sample_t'(t[3]));
        return sat((near * `QID_TAP_NEAR - far * `QID_TAP_FAR) >>> `QID_TAP_SHIFT);
    endfunction

    // Per-stage controls; only the low three bits of a six-bit field pick a mode
    assign byp[0]  = halfband_stage_first_bypass;
    assign byp[1]  = halfband_stage_second_bypass;
    assign byp[2]  = halfband_stage_third_bypass;
    assign mode[0] = {1'b0, halfband_stage_first_mode};
    assign mode[1] = halfband_stage_second_mode[2:0];
    assign mode[2] = halfband_stage_third_mode[2:0];

    // Stages walk from the sink back to the fifo so each take sees its ready
    always_comb begin
        next_st  = st;
        down_rdy = out_ready;
        take     = '0;
        accept   = '0;
        src_i    = '0;
        src_q    = '0;
        src_v    = 1'b0;
        rot      = '0;
        ev       = '0;
        od       = '0;
        step_in  = '0;
        step_out = '0;
        nt_i     = '0;
        nt_q     = '0;
        for (int k = NS - 1; k >= 0; k--) begin
            // Source: premodulated fifo word or the previous stage's output
            if (k == 0) begin
                src_i = qid_sample_t'(fifo_data[2*W-1:W]);
                src_q = qid_sample_t'(fifo_data[W-1:0]);
                if (premod_enable && st.premod_neg) begin
                    rot   = rot_q(src_i, src_q, 2'h2);
                    src_i = qid_sample_t'(rot[2*W-1:W]);
                    src_q = qid_sample_t'(rot[W-1:0]);
                end
                src_v = fifo_valid;
            end else begin
                src_i = qid_sample_t'(st.stg[k-1].out_i);
                src_q = qid_sample_t'(st.stg[k-1].out_q);
                src_v = st.stg[k-1].out_v;
            end
            // A held second sample blocks new input until it is sent
            take[k]   = !st.stg[k].pend_v && (!st.stg[k].out_v || down_rdy);
            accept[k] = take[k] && src_v;
            // Drain the output register, then refill it with the pending sample
            if (st.stg[k].out_v && down_rdy) begin
                if (st.stg[k].pend_v) begin
                    next_st.stg[k].out_i  = st.stg[k].pend_i;
                    next_st.stg[k].out_q  = st.stg[k].pend_q;
                    next_st.stg[k].pend_v = 1'b0;
                end else begin
                    next_st.stg[k].out_v = 1'b0;
                end
            end
            // Step sizes: eighths per output sample, quarters per input sample
            if (k == 0) begin
                step_out = {mode[k][1:0], 1'b0};
                step_in  = {mode[k][0], 1'b0};
            end else begin
                step_out = mode[k];
                step_in  = mode[k][1:0];
            end
            if (accept[k] && byp[k]) begin
                next_st.stg[k].out_i = src_i;
                next_st.stg[k].out_q = src_q;
                next_st.stg[k].out_v = 1'b1;
            end else if (accept[k]) begin
                // Move the pass-band centre to DC, filter, move it back out
                rot  = rot_q(src_i, src_q, 2'(2'h0 - st.stg[k].phi_in));
                nt_i = {st.stg[k].tap_i[`QID_TAPS-2:0], rot[2*W-1:W]};
                nt_q = {st.stg[k].tap_q[`QID_TAPS-2:0], rot[W-1:0]};
                ev   = rot_e(qid_sample_t'(nt_i[2]), qid_sample_t'(nt_q[2]),
                             st.stg[k].phi_out);
                od   = rot_e(hb_odd(nt_i), hb_odd(nt_q),
                             3'(st.stg[k].phi_out + step_out));
                next_st.stg[k].tap_i   = nt_i;
                next_st.stg[k].tap_q   = nt_q;
                next_st.stg[k].out_i   = ev[2*W-1:W];
                next_st.stg[k].out_q   = ev[W-1:0];
                next_st.stg[k].pend_i  = od[2*W-1:W];
                next_st.stg[k].pend_q  = od[W-1:0];
                next_st.stg[k].out_v   = 1'b1;
                next_st.stg[k].pend_v  = 1'b1;
                next_st.stg[k].phi_in  = 2'(st.stg[k].phi_in + step_in);
                next_st.stg[k].phi_out = 3'(st.stg[k].phi_out + {step_out[1:0], 1'b0});
            end
            down_rdy = take[k];
        end
        fifo_take = take[0];
        // Half-rate sign flip alternates on every sample leaving the fifo
        if (take[0] && fifo_valid) begin
            next_st.premod_neg = !st.premod_neg;
        end
    end

    // Single state register; synchronous clear
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the last stage's register
    assign out_i     = qid_sample_t'(st.stg[NS-1].out_i);
    assign out_q     = qid_sample_t'(st.stg[NS-1].out_q);
    assign out_valid = st.stg[NS-1].out_v;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    // Bypassed stage copies its input and never holds a second sample
    a_bypass_copies: assert property (accept[1] && byp[1] |=>
        st.stg[1].out_i == $past(st.stg[0].out_i) && !st.stg[1].pend_v)
        else $error("bypassed stage did not pass the sample through");

    // Active stage yields two samples per input
    a_double_rate: assert property (accept[2] && !byp[2] |=>
        st.stg[2].out_v && st.stg[2].pend_v)
        else $error("active stage did not produce two samples");

    // Pending second sample goes out on the next ready cycle
    a_second_out: assert property (st.stg[2].pend_v && out_ready |=>
        out_valid && !st.stg[2].pend_v)
        else $error("second sample was not delivered");

    // No new input while a second sample waits, so the taps hold still
    a_pend_blocks: assert property (st.stg[0].pend_v |-> !accept[0] ##1
        $stable(st.stg[0].tap_i) && $stable(st.stg[0].tap_q))
        else $error("stage accepted input while holding a sample");

    // Stalled output holds both halves of the complex sample
    a_out_stable: assert property (out_valid && !out_ready |=>
        out_valid && $stable(out_i) && $stable(out_q))
        else $error("output changed while stalled");

    // Second stage output phase advances by twice the mode number
    a_hb2_phase: assert property (accept[1] && !byp[1] |=>
        3'(st.stg[1].phi_out - $past(st.stg[1].phi_out)) ==
        3'({$past(halfband_stage_second_mode[1:0]), 1'b0}))
        else $error("second stage phase step wrong");

    // First stage output phase advances by four eighths per odd mode
    a_hb1_phase: assert property (accept[0] && !byp[0] |=>
        3'(st.stg[0].phi_out - $past(st.stg[0].phi_out)) ==
        {$past(halfband_stage_first_mode[0]), 2'b00})
        else $error("first stage phase step wrong");

    // Non-mixing first stage modes keep the input rotation still
    a_hb1_separate: assert property (accept[0] && !byp[0] && !halfband_stage_first_mode[0]
        |=> $stable(st.stg[0].phi_in))
        else $error("first stage rotated input in a separate mode");

    // Third stage modes 0 and 4 keep the input rotation still
    a_hb3_separate: assert property (accept[2] && !byp[2] &&
        halfband_stage_third_mode[1:0] == 2'h0 |=> $stable(st.stg[2].phi_in))
        else $error("third stage rotated input in a separate mode");

    // Premodulation sign alternates per sample
    a_premod_toggle: assert property (take[0] && fifo_valid |=>
        st.premod_neg != $past(st.premod_neg))
        else $error("premodulation sign did not alternate");

    c_full_chain: cover property (accept[0] && !byp[0] ##1 accept[1] && !byp[1]
        ##1 accept[2] && !byp[2]);
    c_hb2_mode5: cover property (accept[1] && !byp[1] && halfband_stage_second_mode[2:0] == 3'h5);
    c_premod_pass: cover property (premod_enable && accept[0] && byp == 3'h7);
    c_fifo_full: cover property (!in_ready && in_valid);
    c_hb1_mix: cover property (accept[0] && !byp[0] && halfband_stage_first_mode[0]);
endmodule

// [qid_datapath_tb.sv]
// Purpose: Self-checking bench of the quadrature interpolation datapath
// Assumes: Stage outputs start at phase zero after each reset
// Notes:   Filter values are checked on DC input once the taps have settled
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module qid_datapath_tb;
    import qid_pkg::*;
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        premod_enable = 1'b0;
    logic        out_ready = 1'b0;
    logic        ready_mode = 1'b0;
    logic [2:0]  byp = 3'h7;
    logic [1:0]  m1 = 2'h0;
    logic [5:0]  m2 = 6'h00;
    logic [5:0]  m3 = 6'h00;
    logic [7:0]  gap_pct = 8'h00;
    logic        in_valid;
    logic        in_ready;
    logic        out_valid;
    qid_sample_t in_i;
    qid_sample_t in_q;
    qid_sample_t out_i;
    qid_sample_t out_q;
    qid_sample_t got_i[$];
    qid_sample_t got_q[$];
    qid_sample_t exp_i[$];
    qid_sample_t exp_q[$];
    int          num_errors = 0;
    int          cmp_count = 0;

    always #25 core_clk = ~core_clk;

    qid_source src (.core_clk(core_clk), .rst_n(rst_n), .gap_pct(gap_pct), .in_i(in_i),
        .in_q(in_q), .in_valid(in_valid), .in_ready(in_ready));

    qid_datapath dut (.core_clk(core_clk), .rst_n(rst_n), .in_i(in_i), .in_q(in_q),
        .in_valid(in_valid), .in_ready(in_ready), .premod_enable(premod_enable),
        .halfband_stage_first_bypass(byp[0]), .halfband_stage_second_bypass(byp[1]),
        .halfband_stage_third_bypass(byp[2]), .halfband_stage_first_mode(m1),
        .halfband_stage_second_mode(m2), .halfband_stage_third_mode(m3),
        .out_i(out_i), .out_q(out_q), .out_valid(out_valid), .out_ready(out_ready));

    // Sink stalls at random so back-pressure reaches every stage
    always @(posedge core_clk) begin
        out_ready <= ready_mode ? 1'($urandom_range(1)) : 1'b0;
    end

    // Every handed-over output is kept for comparison
    always @(posedge core_clk) begin
        if (rst_n && out_valid === 1'b1 && out_ready) begin
            got_i.push_back(out_i);
            got_q.push_back(out_q);
        end
    end

    task automatic end_sim();
        $display("errors=%0d compares=%0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        got_i.delete();
        got_q.delete();
        exp_i.delete();
        exp_q.delete();
    endtask

    // Bounded wait, then idle so that surplus outputs would show
    task automatic wait_outs(input int n);
        int t;
        t = 0;
        while (got_i.size() < n && t < 20000) begin
            @(posedge core_clk);
            t++;
        end
        if (t >= 20000) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got_i.size(), n);
            end_sim();
        end
        repeat (40) @(posedge core_clk);
    endtask

    // All stages bypassed with junk modes; optional fill of the buffer first
    task automatic run_stream(input logic p, input logic fill);
        int          acc;
        qid_sample_t a;
        qid_sample_t b;
        premod_enable <= p;
        byp <= 3'h7;
        m1 <= 2'($urandom);
        m2 <= 6'($urandom);
        m3 <= 6'($urandom);
        ready_mode <= !fill;
        gap_pct <= fill ? 8'h00 : 8'h1e;
        do_reset();
        for (int k = 0; k < 48; k++) begin
            a = qid_sample_t'(int'($urandom_range(32000)) - 16000);
            b = qid_sample_t'(int'($urandom_range(32000)) - 16000);
            src.push(a, b);
            exp_i.push_back((p && k[0]) ? -a : a);
            exp_q.push_back((p && k[0]) ? -b : b);
        end
        if (fill) begin
            repeat (80) @(posedge core_clk);
            acc = 48 - src.qi.size();
            `CHK(in_ready, 1'b0)
            `CHK(acc >= 32 && acc <= 40, 1'b1)
            ready_mode <= 1'b1;
        end
        wait_outs(48);
        `CHK(got_i.size(), 48)
        for (int k = 0; k < 48; k++) begin
            `CHK(got_i[k], exp_i[k])
            `CHK(got_q[k], exp_q[k])
        end
    endtask

    // DC on I, optionally premodulated: count, then the settled output turns by
    // turn quarter-turns per output sample; even turns must leave Q silent
    task automatic run_dc(input logic [2:0] bm, input logic [1:0] a1, input logic [5:0] a2,
                          input logic [5:0] a3, input logic p, input int turn,
                          input int ratio);
        qid_sample_t c;
        qid_sample_t e_i;
        qid_sample_t e_q;
        int          s;
        byp <= bm;
        m1 <= a1;
        m2 <= a2;
        m3 <= a3;
        premod_enable <= p;
        ready_mode <= 1'b1;
        gap_pct <= 8'h14;
        do_reset();
        c = qid_sample_t'(int'($urandom_range(32000)) - 16000);
        repeat (32) src.push(c, 16'sh0000);
        wait_outs(32 * ratio);
        `CHK(got_i.size(), 32 * ratio)
        for (int k = 0; k < 32 * ratio; k++) begin
            s   = (turn * k) % 4;
            e_i = (s == 0) ? c : ((s == 2) ? -c : 16'sh0000);
            e_q = (s == 1) ? c : ((s == 3) ? -c : 16'sh0000);
            if (turn % 2 == 0) begin
                `CHK(got_q[k], 16'sh0000)
            end else if (k >= 16 * ratio) begin
                `CHK(got_q[k], e_q)
            end
            if (k >= 16 * ratio) begin
                `CHK(got_i[k], e_i)
            end
        end
    endtask

    initial begin
        void'($urandom(42822));
        @(posedge core_clk);
        run_stream(1'b0, 1'b0);
        run_stream(1'b1, 1'b1);
        run_dc(3'b110, 2'h0, 6'h3f, 6'h3f, 1'b0, 0, 2);
        run_dc(3'b110, 2'h2, 6'h3f, 6'h3f, 1'b0, 2, 2);
        run_dc(3'b101, 2'h3, 6'h00, 6'h24, 1'b0, 0, 2);
        run_dc(3'b101, 2'h3, 6'h24, 6'h00, 1'b0, 2, 2);
        run_dc(3'b011, 2'h2, 6'h24, 6'h00, 1'b0, 0, 2);
        run_dc(3'b011, 2'h2, 6'h00, 6'h24, 1'b0, 2, 2);
        run_dc(3'b100, 2'h0, 6'h00, 6'h24, 1'b0, 0, 4);
        run_dc(3'b000, 2'h0, 6'h00, 6'h00, 1'b0, 0, 8);
        // Premodulated tone into the shifted and mixing modes
        run_dc(3'b110, 2'h1, 6'h3f, 6'h3f, 1'b1, 1, 2);
        run_dc(3'b110, 2'h3, 6'h00, 6'h00, 1'b1, 3, 2);
        run_dc(3'b101, 2'h0, 6'h12, 6'h00, 1'b1, 1, 2);
        run_dc(3'b011, 2'h0, 6'h00, 6'h36, 1'b1, 3, 2);
        end_sim();
    end
endmodule

// [qid_defs.svh]
// Purpose: Shared constants of the quadrature interpolation datapath
// Assumes: Included by its bare name; definitions only
// Notes:   Arithmetic constants are 36 bits wide to match the internal sums
`ifndef QID_DEFS_SVH
`define QID_DEFS_SVH

// Sample and structure sizes
`define QID_DATA_W      16
`define QID_FIFO_DEPTH  32
`define QID_NUM_STAGES  3
`define QID_TAPS        4
`define QID_HB1_MODE_W  2
`define QID_HBN_MODE_W  6

// Half-band kernel: near taps, far taps, normalising shift
`define QID_TAP_NEAR    36'sh0_0000_0009
`define QID_TAP_FAR     36'sh0_0000_0001
`define QID_TAP_SHIFT   4

// One over root two in Q15, for eighth-turn rotations
`define QID_ROOT_HALF   36'sh0_0000_5a82
`define QID_ROOT_SHIFT  15

// Saturation limits of a sample
`define QID_SAT_MAX     36'sh0_0000_7fff
`define QID_SAT_MIN     (-36'sh0_0000_8000)

`endif

// [qid_fifo.sv]
// Purpose: Flip-flop FIFO with valid and ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   Write ready is registered, so it lags a pop by one cycle
`timescale 1ns/1ns
module qid_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32
) (
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic             wr_valid,
    output logic                  wr_ready,
    output logic [WIDTH-1:0]      rd_data,
    output logic                  rd_valid,
    input  wire logic             rd_ready
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
        logic                        rdy;
    } qid_fifo_s;

    qid_fifo_s st;
    qid_fifo_s next_st;
    logic      push;
    logic      pop;

    // Pointer and count update; push and pop may share a cycle
    always_comb begin
        next_st = st;
        push    = wr_valid && st.rdy;
        pop     = rd_ready && (st.cnt != '0);
        if (push) begin
            next_st.mem[st.wp] = wr_data;
            next_st.wp         = AW'(st.wp + 1'b1);
        end
        if (pop) begin
            next_st.rp = AW'(st.rp + 1'b1);
        end
        if (push && !pop) begin
            next_st.cnt = (AW+1)'(st.cnt + 1'b1);
        end else if (pop && !push) begin
            next_st.cnt = (AW+1)'(st.cnt - 1'b1);
        end
        // Full is judged on the next count, so no write is ever dropped
        next_st.rdy = (next_st.cnt != (AW+1)'(DEPTH));
    end

    // Ready stays low in reset so nothing is taken before release
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign wr_ready = st.rdy;
    assign rd_data  = st.mem[st.rp];
    assign rd_valid = (st.cnt != '0);
endmodule

// [qid_pkg.sv]
// Purpose: Types of the quadrature interpolation datapath
// Assumes: qid_defs.svh supplies the sizes
// Notes:   One stage record per half-band interpolator
package qid_pkg;
`include "qid_defs.svh"

    typedef logic signed [`QID_DATA_W-1:0] qid_sample_t;
    typedef logic [2:0]                    qid_mode_t;

    // State of one half-band stage
    typedef struct packed {
        logic [`QID_TAPS-1:0][`QID_DATA_W-1:0] tap_i;
        logic [`QID_TAPS-1:0][`QID_DATA_W-1:0] tap_q;
        logic [`QID_DATA_W-1:0]                out_i;
        logic [`QID_DATA_W-1:0]                out_q;
        logic [`QID_DATA_W-1:0]                pend_i;
        logic [`QID_DATA_W-1:0]                pend_q;
        logic                                  out_v;
        logic                                  pend_v;
        logic [1:0]                            phi_in;
        logic [2:0]                            phi_out;
    } qid_stage_s;

    // Whole datapath state
    typedef struct packed {
        qid_stage_s [`QID_NUM_STAGES-1:0] stg;
        logic                             premod_neg;
    } qid_state_s;
endpackage

// [qid_source.sv]
// Purpose: Upstream sample source feeding the datapath input stream
// Assumes: Bench queues samples with push; one sample offered at a time
// Notes:   Released data lines show the inverse of the last value
`timescale 1ns/1ns
module qid_source (
    input  wire logic           core_clk,
    input  wire logic           rst_n,
    input  wire logic [7:0]     gap_pct,
    output qid_pkg::qid_sample_t in_i,
    output qid_pkg::qid_sample_t in_q,
    output logic                in_valid,
    input  wire logic           in_ready
);
    import qid_pkg::*;
    qid_sample_t qi[$];
    qid_sample_t qq[$];

    // I and Q are queued and offered as one pair
    task automatic push(input qid_sample_t i, input qid_sample_t q);
        qi.push_back(i);
        qq.push_back(q);
    endtask

    // Offer held until taken; random gaps model a slow source
    always @(posedge core_clk) begin
        if (!rst_n) begin
            in_valid <= 1'b0;
            in_i     <= '0;
            in_q     <= '0;
        end else if (!in_valid || in_ready) begin
            if (in_valid) begin
                void'(qi.pop_front());
                void'(qq.pop_front());
            end
            if (qi.size() > 0 && $urandom_range(99) >= gap_pct) begin
                in_valid <= 1'b1;
                in_i <= qi[0];
                in_q <= qq[0];
            end else begin
                in_valid <= 1'b0;
                in_i <= ~in_i; // Stale value must never look valid
                in_q <= ~in_q;
            end
        end
    end
endmodule
